// [src/ldc_top.sv]
// Control logic of a 5-bit ladder reference converter with register port.
// Assumes a same-clock register master and an asynchronous pin input.
//
// Functional notes
// - Ladder active only while enable bit 7 set.
// - Thirty-two levels from five-bit level code.
// - Enabled tap equals level code, ratiometric output.
// - Disabled, idle select one: tap all ones.
// - Disabled, idle select zero: tap all zeros.
// - High source select bits 3:2 choose source.
// - Bit 0 picks external low reference or ground.
// - Bit 5 routes level onto output pin.
// - Routed pin: digital driver and detector off.
// - Routed pin digital read returns zero.
// - Level feeds comparator, ADC, pin, touch unit.
// - Control bits 4 and 1 read zero.
// - Level code in bits 4:0, upper zero.
`timescale 1ns/1ps
module ldc_top
	import ldc_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_RESET_N,
	input wire logic [LDC_AW-1:0] I_ADDR,
	input wire logic [LDC_DW-1:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic I_PIN_IN,
	input wire logic I_PIN_DIG_OUT,
	input wire logic I_PIN_DIG_OE,
	output logic [LDC_DW-1:0] O_RDATA,
	output logic O_LADDER_ON,
	output logic [LDC_LW-1:0] O_TAP,
	output logic [3:0] O_HIGH_SRC,
	output logic O_LOW_EXT,
	output logic O_PIN_ROUTE,
	output logic O_PIN_DIG_OFF,
	output logic O_PIN_OUT,
	output logic O_PIN_OE,
	output logic O_PIN_READ,
	output logic O_REF_CMP,
	output logic O_REF_ADC,
	output logic O_REF_TOUCH
);
	logic [LDC_DW-1:0] ctrl0;
	logic [LDC_DW-1:0] level;
	logic we_ctrl0;
	logic we_level;
	logic [LDC_DW-1:0] rdata_d;
	logic [LDC_DW-1:0] rdata_q;
	logic pin_s1_q;
	logic pin_s2_q;
	logic pin_s1_d;
	logic pin_s2_d;
	ldc_ana_s ana_d;
	ldc_ana_s ana_q;
	logic pin_out_d;
	logic pin_out_q;
	logic pin_oe_d;
	logic pin_oe_q;
	logic pin_read_d;
	logic pin_read_q;
	ldc_hsrc_e hsrc;
	logic conv_en;
	logic idle_hi;
	logic route;

	// Write decode for the two control registers.
	assign we_ctrl0 = I_WR && (I_ADDR == LDC_OFS_CTRL0);
	assign we_level = I_WR && (I_ADDR == LDC_OFS_LEVEL);

	// First control register; bits 4 and 1 are never stored.
	ldc_reg_mask #(
		.WMASK(LDC_CTRL0_WMASK),
		.RSTV(LDC_CTRL0_RST)
	) u_ctrl0 (
		.i_clk(I_CLK),
		.i_reset_n(I_RESET_N),
		.i_we(we_ctrl0),
		.i_wdata(I_WDATA),
		.o_q(ctrl0)
	);

	// Level register, right-justified five-bit code, upper bits zero.
	ldc_reg_mask #(
		.WMASK(LDC_LEVEL_WMASK),
		.RSTV(LDC_LEVEL_RST)
	) u_level (
		.i_clk(I_CLK),
		.i_reset_n(I_RESET_N),
		.i_we(we_level),
		.i_wdata(I_WDATA),
		.o_q(level)
	);

	// Field extraction from the first control register.
	assign conv_en = ctrl0[LDC_BIT_EN];
	assign idle_hi = ctrl0[LDC_BIT_IDLE];
	assign route = ctrl0[LDC_BIT_OE];

	// Read mux; data appear in the cycle after the strobe only.
	always_comb begin
		rdata_d = LDC_RD_UNMAPPED;
		if (I_RD) begin
			case (I_ADDR)
				LDC_OFS_CTRL0: begin
					rdata_d = ctrl0;
				end
				LDC_OFS_LEVEL: begin
					rdata_d = level;
				end
				default: begin
					rdata_d = LDC_RD_UNMAPPED;
				end
			endcase
		end
	end

	// High-source decode; the reserved code selects nothing.
	always_comb begin
		case (ctrl0[LDC_BIT_HS_HI:LDC_BIT_HS_LO])
			LDC_HS_SUPPLY: begin
				hsrc = LDC_SRC_SUPPLY;
			end
			LDC_HS_EXTREF: begin
				hsrc = LDC_SRC_EXTREF;
			end
			LDC_HS_FIXREF: begin
				hsrc = LDC_SRC_FIXREF;
			end
			default: begin
				hsrc = LDC_SRC_NONE;
			end
		endcase
	end

	// Analog control bundle, registered so outputs come from flops.
	always_comb begin
		ana_d = '0;
		ana_d.ladder_on = conv_en;
		if (conv_en) begin
			ana_d.tap = level[LDC_LW-1:0];
		end else if (idle_hi) begin
			ana_d.tap = LDC_TAP_ALL_ONES;
		end else begin
			ana_d.tap = LDC_TAP_ALL_ZEROS;
		end
		ana_d.high_src = hsrc;
		ana_d.low_ext = ctrl0[LDC_BIT_LS];
		ana_d.pin_route = route;
		ana_d.pin_dig_off = route;
		ana_d.ref_cmp = conv_en;
		ana_d.ref_adc = conv_en;
		ana_d.ref_touch = conv_en;
	end

	// Pin path: digital driver and detector overridden while routed.
	always_comb begin
		pin_s1_d = I_PIN_IN;
		pin_s2_d = pin_s1_q;
		pin_out_d = route ? 1'b0 : I_PIN_DIG_OUT;
		pin_oe_d = route ? 1'b0 : I_PIN_DIG_OE;
		pin_read_d = route ? 1'b0 : pin_s2_q;
	end

	// Read-data, analog and pin registers; reset clears every output.
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			rdata_q <= '0;
			ana_q <= '0;
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pin_out_q <= 1'b0;
			pin_oe_q <= 1'b0;
			pin_read_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			ana_q <= ana_d;
			pin_s1_q <= pin_s1_d;
			pin_s2_q <= pin_s2_d;
			pin_out_q <= pin_out_d;
			pin_oe_q <= pin_oe_d;
			pin_read_q <= pin_read_d;
		end
	end

	// Output assignments straight from flops.
	assign O_RDATA = rdata_q;
	assign O_LADDER_ON = ana_q.ladder_on;
	assign O_TAP = ana_q.tap;
	assign O_HIGH_SRC = ana_q.high_src;
	assign O_LOW_EXT = ana_q.low_ext;
	assign O_PIN_ROUTE = ana_q.pin_route;
	assign O_PIN_DIG_OFF = ana_q.pin_dig_off;
	assign O_PIN_OUT = pin_out_q;
	assign O_PIN_OE = pin_oe_q;
	assign O_PIN_READ = pin_read_q;
	assign O_REF_CMP = ana_q.ref_cmp;
	assign O_REF_ADC = ana_q.ref_adc;
	assign O_REF_TOUCH = ana_q.ref_touch;
endmodule

// [src/ldc_pkg.sv]
// Package for the ladder converter control block: offsets, fields, types.
// Assumes an 8-bit register port with one-cycle read latency.
package ldc_pkg;
	localparam int unsigned LDC_AW = 4;
	localparam int unsigned LDC_DW = 8;
	localparam int unsigned LDC_LW = 5;
	localparam logic [LDC_AW-1:0] LDC_OFS_CTRL0 = 4'h0;
	localparam logic [LDC_AW-1:0] LDC_OFS_LEVEL = 4'h1;
	localparam logic [LDC_DW-1:0] LDC_CTRL0_RST = 8'h00;
	localparam logic [LDC_DW-1:0] LDC_LEVEL_RST = 8'h00;
	localparam logic [LDC_DW-1:0] LDC_RD_UNMAPPED = 8'h00;
	localparam int unsigned LDC_BIT_EN = 7;
	localparam int unsigned LDC_BIT_IDLE = 6;
	localparam int unsigned LDC_BIT_OE = 5;
	localparam int unsigned LDC_BIT_HS_HI = 3;
	localparam int unsigned LDC_BIT_HS_LO = 2;
	localparam int unsigned LDC_BIT_LS = 0;
	localparam logic [LDC_DW-1:0] LDC_CTRL0_WMASK = 8'hed;
	localparam logic [LDC_DW-1:0] LDC_LEVEL_WMASK = 8'h1f;
	localparam logic [LDC_LW-1:0] LDC_TAP_ALL_ONES = 5'h1f;
	localparam logic [LDC_LW-1:0] LDC_TAP_ALL_ZEROS = 5'h00;
	localparam logic [1:0] LDC_HS_SUPPLY = 2'h0;
	localparam logic [1:0] LDC_HS_EXTREF = 2'h1;
	localparam logic [1:0] LDC_HS_FIXREF = 2'h2;
	localparam logic [1:0] LDC_HS_RSVD = 2'h3;

	// One-hot source selection for the high end of the ladder.
	typedef enum logic [3:0] {
		LDC_SRC_NONE = 4'h1,
		LDC_SRC_SUPPLY = 4'h2,
		LDC_SRC_EXTREF = 4'h4,
		LDC_SRC_FIXREF = 4'h8
	} ldc_hsrc_e;

	// Analog-side control bundle.
	typedef struct packed {
		logic ladder_on;
		logic [LDC_LW-1:0] tap;
		logic [3:0] high_src;
		logic low_ext;
		logic pin_route;
		logic pin_dig_off;
		logic ref_cmp;
		logic ref_adc;
		logic ref_touch;
	} ldc_ana_s;
endpackage

// [src/ldc_reg_mask.sv]
// Masked byte register: holds only its writable bits, others read as zero.
// Assumes a same-clock write strobe from the register port.
`timescale 1ns/1ps
module ldc_reg_mask
	import ldc_pkg::*;
#(
	parameter logic [LDC_DW-1:0] WMASK = 8'hff,
	parameter logic [LDC_DW-1:0] RSTV = 8'h00
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_we,
	input wire logic [LDC_DW-1:0] i_wdata,
	output logic [LDC_DW-1:0] o_q
);
	logic [LDC_DW-1:0] val_d;
	logic [LDC_DW-1:0] val_q;

	// Next value keeps unimplemented bits at zero.
	always_comb begin
		val_d = val_q;
		if (i_we) begin
			val_d = i_wdata & WMASK;
		end
	end

	// State register.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			val_q <= RSTV;
		end else begin
			val_q <= val_d;
		end
	end

	assign o_q = val_q;
endmodule

// [bench/ldc_checker.sv]
// Port checker for the ladder converter control block.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module ldc_checker
	import ldc_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_RESET_N,
	input wire logic [LDC_AW-1:0] I_ADDR,
	input wire logic [LDC_DW-1:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic I_PIN_DIG_OE,
	input wire logic [LDC_DW-1:0] O_RDATA,
	input wire logic O_LADDER_ON,
	input wire logic [LDC_LW-1:0] O_TAP,
	input wire logic [3:0] O_HIGH_SRC,
	input wire logic O_LOW_EXT,
	input wire logic O_PIN_ROUTE,
	input wire logic O_PIN_DIG_OFF,
	input wire logic O_PIN_OUT,
	input wire logic O_PIN_OE,
	input wire logic O_PIN_READ,
	input wire logic O_REF_CMP
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RESET_N);
	// A control write; its outputs settle two edges later.
	sequence s_wr0;
		I_WR && I_ADDR == LDC_OFS_CTRL0;
	endsequence
	a_ctrl_bits: assert property (s_wr0 |-> ##2
		($past(I_WDATA, 2) & 8'ha1) ==
		{O_LADDER_ON, 1'b0, O_PIN_ROUTE, 4'h0, O_LOW_EXT})
		else $error("ctrl");
	a_idle_tap: assert property (s_wr0 ##0 !I_WDATA[7] |-> ##2
		O_TAP == (($past(I_WDATA, 2) & 8'h40) != 0 ? 5'h1f : 5'h00))
		else $error("idle");
	a_src_map: assert property (s_wr0 |-> ##2 O_HIGH_SRC ==
		(($past(I_WDATA, 2) & 8'h0c) == 8'h0c ? 4'h1 :
		4'h2 << $past(I_WDATA[3:2], 2))) else $error("src");
	a_ref_en: assert property (O_REF_CMP == O_LADDER_ON)
		else $error("ref");
	a_dig_off: assert property (O_PIN_DIG_OFF == O_PIN_ROUTE)
		else $error("off");
	a_pin_quiet: assert property (O_PIN_ROUTE && $past(O_PIN_ROUTE) |->
		!(O_PIN_OUT | O_PIN_OE | O_PIN_READ)) else $error("pin");
	a_oe_pass: assert property (!O_PIN_ROUTE && !$past(O_PIN_ROUTE) &&
		$past(I_RESET_N) |-> O_PIN_OE == $past(I_PIN_DIG_OE))
		else $error("oe");
	a_rd_unmap: assert property (I_RD && I_ADDR > LDC_OFS_LEVEL |=>
		O_RDATA == LDC_RD_UNMAPPED) else $error("unmapped");
	a_rd_quiet: assert property (!I_RD |=> O_RDATA == 8'h00)
		else $error("rd");
endmodule

bind ldc_top ldc_checker ldc_checker_i (.*);

// [bench/ldc_tb_top.sv]
// Random self-checking bench for the ladder converter control block.
// Assumes ldc_top with its bound checker and a 100 MHz clock.
`timescale 1ns/1ps
module ldc_tb_top;
	import ldc_pkg::*;
	logic I_CLK = 0, I_RESET_N = 0, I_WR = 0, I_RD = 0;
	logic I_PIN_IN = 0, I_PIN_DIG_OUT = 0, I_PIN_DIG_OE = 0;
	logic [LDC_AW-1:0] I_ADDR = 0, a;
	logic [LDC_DW-1:0] I_WDATA = 0, O_RDATA, c, l, rdv;
	logic O_LADDER_ON, O_LOW_EXT, O_PIN_ROUTE, O_PIN_DIG_OFF, O_PIN_OUT;
	logic O_PIN_OE, O_PIN_READ, O_REF_CMP, O_REF_ADC, O_REF_TOUCH;
	logic [LDC_LW-1:0] O_TAP;
	logic [3:0] O_HIGH_SRC;
	logic [31:0] r;
	logic [7:0] ct [5] = '{8'h80, 8'h40, 8'h00, 8'hf7, 8'h29};
	logic [7:0] lt [5] = '{8'h1f, 8'h0a, 8'hff, 8'h00, 8'he5};
	int num_errors = 0, n_checks = 0;
	integer seed = 97;
	ldc_top ldc_top_i (.*);
	// Free-running clock.
	initial forever #5 I_CLK = ~I_CLK;
	// Expected tap code from the control and level bytes.
	function automatic logic [7:0] exp_tap(logic [7:0] cv, lv);
		return cv[7] ? lv & 8'h1f : (cv[6] ? 8'h1f : 8'h00);
	endfunction
	// Compares one value and counts it.
	task automatic chk(string nm, logic [7:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// One bus cycle; read data is taken in the cycle after the strobe.
	task automatic bus(logic w, logic [3:0] ad, logic [7:0] d);
		@(posedge I_CLK);
		I_WR <= w;
		I_RD <= !w;
		I_ADDR <= ad;
		I_WDATA <= d;
		@(posedge I_CLK);
		I_WR <= 0;
		I_RD <= 0;
		#1 rdv = O_RDATA;
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		#100000;
		num_errors++;
		wrap_up();
	end
	// Main sequence: corner table first, then random settings.
	initial begin
		repeat (6) @(posedge I_CLK);
		I_RESET_N <= 1;
		bus(0, LDC_OFS_CTRL0, 0);
		chk("ctrl0 reset", rdv, LDC_CTRL0_RST);
		bus(0, LDC_OFS_LEVEL, 0);
		chk("level reset", rdv, LDC_LEVEL_RST);
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			c = r[31:24];
			l = r[23:16];
			if (i < 5) begin
				c = ct[i];
				l = lt[i];
			end
			c[3] = c[3] & ~c[2];
			a = r[7:4] | 4'h2;
			@(posedge I_CLK);
			I_PIN_IN <= r[0];
			I_PIN_DIG_OUT <= r[1];
			I_PIN_DIG_OE <= r[2];
			bus(1, LDC_OFS_CTRL0, c);
			bus(1, LDC_OFS_LEVEL, l);
			bus(1, a, r[15:8]);
			repeat (2) @(posedge I_CLK);
			#1 chk("enable", O_LADDER_ON, c[7]);
			chk("tap", O_TAP, exp_tap(c, l));
			chk("high src", O_HIGH_SRC, 4'h2 << c[3:2]);
			chk("low src", O_LOW_EXT, c[0]);
			chk("route", {O_PIN_ROUTE, O_PIN_DIG_OFF}, {2{c[5]}});
			chk("refs", {O_REF_CMP, O_REF_ADC, O_REF_TOUCH}, {3{c[7]}});
			chk("pin", {O_PIN_OUT, O_PIN_OE, O_PIN_READ},
				c[5] ? 3'h0 : {r[1], r[2], r[0]});
			bus(0, LDC_OFS_CTRL0, 0);
			chk("ctrl0 read", rdv, c & 8'hed);
			bus(0, LDC_OFS_LEVEL, 0);
			chk("level read", rdv, l & 8'h1f);
			bus(0, a, 0);
			chk("unmapped read", rdv, 8'h00);
		end
		@(posedge I_CLK);
		I_RESET_N <= 0;
		@(posedge I_CLK);
		#1 chk("reset outs", {O_LADDER_ON, O_TAP, O_PIN_ROUTE}, 8'h00);
		chk("reset pins", {O_PIN_OUT, O_PIN_OE, O_PIN_READ}, 8'h00);
		chk("reset src", O_HIGH_SRC, 8'h00);
		chk("reset rdata", O_RDATA, 8'h00);
		@(posedge I_CLK);
		I_RESET_N <= 1;
		bus(0, LDC_OFS_CTRL0, 0);
		chk("ctrl0 again", rdv, LDC_CTRL0_RST);
		chk("src after", O_HIGH_SRC, 4'h2);
		wrap_up();
	end
endmodule
